/* File: mai_alu_core.sv */
// execution datapath: register file, status flags, program counter
// assumes operands are decoded outside and held beside a one-cycle start
// Function
// - add and add-with-carry write sum, set Z C N V H, one cycle
// - word add of immediate to pair, set Z C N V S, two cycles
// - subtract register or constant, set Z C N V H, one cycle
// - subtract with borrow, register or constant, set Z C N V H
// - word subtract of immediate from pair, set Z C N V S, two cycles
// - and, or with register or constant, xor with register only, set only Z N V
// - set selected bits ors mask in, sets Z N V, one cycle
// - clear selected bits ands with FF minus mask, sets Z N V
// - zero-or-minus check keeps value, sets Z N V, one cycle
// - integer multiplies write 16-bit product to r1:r0, Z C, two cycles
// - fractional multiplies shift product left once before writing
// - indirect jump loads pc from pointer pair, flags kept, two cycles
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module mai_alu_core
    import mai_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic opStart,
    input wire mai_op_t opCode,
    input wire logic [4:0] dstIdx,
    input wire logic [4:0] srcIdx,
    input wire logic [DATA_W-1:0] immK,
    output logic opReady,
    input wire logic [ADDR_W-1:0] busAddr,
    input wire logic [DATA_W-1:0] busWrData,
    input wire logic busWrStb,
    input wire logic busRdStb,
    output logic [DATA_W-1:0] busRdData,
    output logic [DATA_W-1:0] statusOut,
    output logic [15:0] pcOut,
    output logic [15:0] resultWord
);
    logic [DATA_W-1:0] gpr [REG_COUNT];
    mai_state_t state;
    mai_op_t holdOp;
    logic [4:0] holdDst;
    logic [15:0] holdWord;
    logic [7:0] holdStatus;

    logic take, commit, isDouble, useImm, useCarry, writeByte;
    logic [7:0] opA, opB, next_res8, next_status;
    logic [15:0] pairVal, next_wide;
    logic [8:0] sum9, dif9, a9, b9;
    logic [4:0] sumH, difH;
    logic [16:0] wordSum, wordDif;
    logic signed [17:0] prod18;
    logic [15:0] prod16;
    logic [4:0] pairHi;

    assign take = opStart && (state == ST_ISSUE);
    assign commit = (state == ST_COMMIT);
    assign pairHi = 5'(dstIdx + PAIR_STEP);
    assign opA = gpr[dstIdx];
    assign useImm = opCode inside {OP_DIFF_IMM, OP_DIFF_BORROW_IMM,
        OP_CONJ_IMM, OP_DISJ_IMM, OP_SET_BITS, OP_CLR_BITS};
    assign opB = useImm ? immK : gpr[srcIdx];
    assign useCarry = opCode inside {OP_PLUS_CARRY, OP_DIFF_BORROW,
        OP_DIFF_BORROW_IMM};
    assign isDouble = opCode inside {OP_WORD_PLUS, OP_WORD_DIFF, OP_PROD_U,
        OP_PROD_S, OP_PROD_SU, OP_FPROD_U, OP_FPROD_S, OP_FPROD_SU,
        OP_IND_BRANCH};

    // byte carries come out of widened sums; word carries use per-bit equations
    assign sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, useCarry & statusOut[FLAG_C]};
    assign sumH = {1'b0, opA[3:0]} + {1'b0, opB[3:0]}
        + {4'h0, useCarry & statusOut[FLAG_C]};
    assign dif9 = {1'b0, opA} - {1'b0, opB} - {8'h00, useCarry & statusOut[FLAG_C]};
    assign difH = {1'b0, opA[3:0]} - {1'b0, opB[3:0]}
        - {4'h0, useCarry & statusOut[FLAG_C]};
    assign pairVal = {gpr[pairHi], opA};
    assign wordSum = {1'b0, pairVal} + {9'h000, immK};
    assign wordDif = {1'b0, pairVal} - {9'h000, immK};

    // one 9x9 signed multiplier serves all six forms by operand extension
    assign a9 = (opCode inside {OP_PROD_S, OP_PROD_SU, OP_FPROD_S,
        OP_FPROD_SU}) ? {opA[7], opA} : {1'b0, opA};
    assign b9 = (opCode inside {OP_PROD_S, OP_FPROD_S}) ? {opB[7], opB}
        : {1'b0, opB};
    assign prod18 = $signed(a9) * $signed(b9);
    assign prod16 = prod18[15:0];

    always_comb begin
        next_res8 = opA;
        next_wide = pairVal;
        next_status = statusOut;
        writeByte = 1'b0;
        case (opCode)
            OP_PLUS, OP_PLUS_CARRY: begin
                next_res8 = sum9[7:0];
                next_status[FLAG_C] = sum9[8];
                next_status[FLAG_H] = sumH[4];
                next_status[FLAG_V] = (opA[7] == opB[7])
                    && (sum9[7] != opA[7]);
                writeByte = 1'b1;
            end
            OP_DIFF, OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_BORROW_IMM: begin
                next_res8 = dif9[7:0];
                next_status[FLAG_C] = dif9[8];
                next_status[FLAG_H] = difH[4];
                next_status[FLAG_V] = (opA[7] != opB[7])
                    && (dif9[7] != opA[7]);
                writeByte = 1'b1;
            end
            OP_CONJ, OP_CONJ_IMM: begin
                next_res8 = opA & opB;
                writeByte = 1'b1;
            end
            OP_DISJ, OP_DISJ_IMM, OP_SET_BITS: begin
                next_res8 = opA | opB;
                writeByte = 1'b1;
            end
            OP_EXCL: begin
                next_res8 = opA ^ opB;
                writeByte = 1'b1;
            end
            OP_CLR_BITS: begin
                next_res8 = opA & (FULL_MASK - opB);
                writeByte = 1'b1;
            end
            OP_ZERO_MINUS: begin
                next_res8 = opA & opA;
                writeByte = 1'b1;
            end
            OP_WORD_PLUS: begin
                next_wide = wordSum[15:0];
                next_status[FLAG_V] = !pairVal[15] && wordSum[15];
                next_status[FLAG_C] = !wordSum[15] && pairVal[15];
            end
            OP_WORD_DIFF: begin
                next_wide = wordDif[15:0];
                next_status[FLAG_V] = pairVal[15] && !wordDif[15];
                next_status[FLAG_C] = wordDif[15] && !pairVal[15];
            end
            OP_PROD_U, OP_PROD_S, OP_PROD_SU: begin
                next_wide = prod16;
                next_status[FLAG_C] = prod16[15];
                next_status[FLAG_Z] = (prod16 == 16'h0000);
            end
            OP_FPROD_U, OP_FPROD_S, OP_FPROD_SU: begin
                next_wide = {prod16[14:0], 1'b0};
                next_status[FLAG_C] = prod16[15];
                next_status[FLAG_Z] = (prod16[14:0] == 15'h0000);
            end
            OP_IND_BRANCH: begin
                next_wide = {gpr[PTR_HI_IDX], gpr[PTR_LO_IDX]};
            end
            default: begin
                next_res8 = opA;
            end
        endcase
        if (writeByte) begin
            next_status[FLAG_N] = next_res8[7];
            next_status[FLAG_Z] = (next_res8 == 8'h00);
            // borrow chains keep Z only when every byte so far was zero
            if (opCode inside {OP_DIFF_BORROW, OP_DIFF_BORROW_IMM}) begin
                next_status[FLAG_Z] = (next_res8 == 8'h00)
                    && statusOut[FLAG_Z];
            end
            if (!(opCode inside {OP_PLUS, OP_PLUS_CARRY, OP_DIFF,
                OP_DIFF_IMM, OP_DIFF_BORROW, OP_DIFF_BORROW_IMM})) begin
                next_status[FLAG_V] = 1'b0;
            end
        end
        if (opCode inside {OP_WORD_PLUS, OP_WORD_DIFF}) begin
            next_status[FLAG_N] = next_wide[15];
            next_status[FLAG_Z] = (next_wide == 16'h0000);
            next_status[FLAG_S] = next_wide[15] ^ next_status[FLAG_V];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_ISSUE;
            opReady <= 1'b1;
        end else begin
            case (state)
                ST_ISSUE: begin
                    if (take && isDouble) begin
                        state <= ST_COMMIT;
                        opReady <= 1'b0;
                    end
                end
                ST_COMMIT: begin
                    state <= ST_ISSUE;
                    opReady <= 1'b1;
                end
                default: begin
                    state <= ST_ISSUE;
                    opReady <= 1'b1;
                end
            endcase
        end
    end

    // results of two-cycle work wait here for the commit cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            holdOp <= OP_NOP;
            holdDst <= 5'h00;
            holdWord <= 16'h0000;
            holdStatus <= STATUS_RESET;
        end else if (take && isDouble) begin
            holdOp <= opCode;
            holdDst <= dstIdx;
            holdWord <= next_wide;
            holdStatus <= next_status;
        end
    end

    // datapath writes land after bus writes so a clash keeps the result
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                gpr[i] <= 8'h00;
            end
        end else begin
            if (busWrStb && busAddr <= ADDR_GPR_LAST) begin
                gpr[busAddr[4:0]] <= busWrData;
            end
            if (take && writeByte) begin
                gpr[dstIdx] <= next_res8;
            end
            if (commit) begin
                case (holdOp)
                    OP_WORD_PLUS, OP_WORD_DIFF: begin
                        gpr[holdDst] <= holdWord[7:0];
                        gpr[5'(holdDst + PAIR_STEP)] <= holdWord[15:8];
                    end
                    OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FPROD_U,
                    OP_FPROD_S, OP_FPROD_SU: begin
                        gpr[PROD_LO_IDX] <= holdWord[7:0];
                        gpr[PROD_HI_IDX] <= holdWord[15:8];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            statusOut <= STATUS_RESET;
        end else if (take && !isDouble && opCode != OP_NOP) begin
            statusOut <= next_status;
        end else if (commit) begin
            statusOut <= holdStatus;
        end else if (busWrStb && busAddr == ADDR_STATUS) begin
            statusOut <= busWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pcOut <= PC_RESET;
        end else if (commit && holdOp == OP_IND_BRANCH) begin
            pcOut <= holdWord;
        end else if (busWrStb && busAddr == ADDR_PC_LO) begin
            pcOut[7:0] <= busWrData;
        end else if (busWrStb && busAddr == ADDR_PC_HI) begin
            pcOut[15:8] <= busWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            resultWord <= 16'h0000;
        end else if (take && writeByte) begin
            resultWord <= {8'h00, next_res8};
        end else if (commit && holdOp != OP_IND_BRANCH) begin
            resultWord <= holdWord;
        end
    end

    // read data stand one cycle after each strobed cycle and clear once the strobe drops; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (rst || !busRdStb) begin
            busRdData <= 8'h00;
        end else if (busAddr <= ADDR_GPR_LAST) begin
            busRdData <= gpr[busAddr[4:0]];
        end else if (busAddr == ADDR_STATUS) begin
            busRdData <= statusOut;
        end else if (busAddr == ADDR_PC_LO) begin
            busRdData <= pcOut[7:0];
        end else if (busAddr == ADDR_PC_HI) begin
            busRdData <= pcOut[15:8];
        end else begin
            busRdData <= 8'h00;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    add_result_a: assert property (take && opCode == OP_PLUS |=>
        resultWord[7:0] == 8'($past(opA) + $past(opB)) && opReady)
        else $error("add result wrong");
    diff_result_a: assert property (take && opCode == OP_DIFF_IMM |=>
        resultWord[7:0] == 8'($past(opA) - $past(immK))
        && statusOut[FLAG_C] == ($past(opA) < $past(immK)))
        else $error("subtract result or carry wrong");
    borrow_zero_a: assert property (take && opCode == OP_DIFF_BORROW |=>
        !statusOut[FLAG_Z] || $past(statusOut[FLAG_Z]))
        else $error("borrow chain zero flag set wrongly");
    logic_carry_a: assert property (take && opCode == OP_CONJ |=>
        statusOut[FLAG_C] == $past(statusOut[FLAG_C]) && !statusOut[FLAG_V]
        && resultWord[7:0] == ($past(opA) & $past(opB)))
        else $error("logic op touched carry or wrong value");
    clear_bits_a: assert property (take && opCode == OP_CLR_BITS |=>
        resultWord[7:0] == ($past(opA) & ~$past(immK)))
        else $error("clear bits wrong");
    zero_check_a: assert property (take && opCode == OP_ZERO_MINUS |=>
        statusOut[FLAG_Z] == ($past(opA) == 8'h00)
        && statusOut[FLAG_N] == $past(opA[7]))
        else $error("zero-or-minus flags wrong");
    word_add_a: assert property (take && opCode == OP_WORD_PLUS |=>
        !opReady ##1 opReady
        && resultWord == 16'($past(pairVal, 2) + {8'h00, $past(immK, 2)}))
        else $error("word add wrong");
    product_pair_a: assert property (take && opCode == OP_PROD_U |=>
        ##1 {gpr[PROD_HI_IDX], gpr[PROD_LO_IDX]}
        == $past(opA, 2) * $past(opB, 2)
        && statusOut[FLAG_C] == resultWord[15])
        else $error("unsigned product wrong");
    frac_shift_a: assert property (take && opCode == OP_FPROD_U |=>
        ##1 resultWord == ($past(opA, 2) * $past(opB, 2)) << 1)
        else $error("fractional product wrong");
    ind_jump_a: assert property (take && opCode == OP_IND_BRANCH |=>
        !opReady ##1 pcOut == $past({gpr[PTR_HI_IDX], gpr[PTR_LO_IDX]}, 2)
        && statusOut == $past(statusOut, 2))
        else $error("indirect jump wrong");
    hold_off_a: assert property (take && isDouble |=>
        !opReady && state == ST_COMMIT ##1 opReady)
        else $error("two-cycle hold-off wrong");
endmodule

/* File: mai_pkg.sv */
// shared constants and types of the 8-bit execution datapath
// assumes one core clock; operand fields come from an outside decoder
package mai_pkg;
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 32;
    localparam int ADDR_W = 6;
    // register port map
    localparam logic [5:0] ADDR_GPR_LAST = 6'h1F;
    localparam logic [5:0] ADDR_STATUS = 6'h20;
    localparam logic [5:0] ADDR_PC_LO = 6'h21;
    localparam logic [5:0] ADDR_PC_HI = 6'h22;
    // status bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [4:0] PROD_LO_IDX = 5'h00;
    localparam logic [4:0] PROD_HI_IDX = 5'h01;
    localparam logic [4:0] PTR_LO_IDX = 5'h1E;
    localparam logic [4:0] PTR_HI_IDX = 5'h1F;
    localparam logic [4:0] PAIR_STEP = 5'h01;
    // cycles per operation class
    localparam int CYC_SINGLE = 1;
    localparam int CYC_DOUBLE = 2;

    typedef enum logic [4:0] {
        OP_NOP, OP_PLUS, OP_PLUS_CARRY, OP_DIFF, OP_DIFF_IMM,
        OP_DIFF_BORROW, OP_DIFF_BORROW_IMM, OP_CONJ, OP_CONJ_IMM,
        OP_DISJ, OP_DISJ_IMM, OP_EXCL, OP_SET_BITS, OP_CLR_BITS,
        OP_ZERO_MINUS, OP_WORD_PLUS, OP_WORD_DIFF, OP_PROD_U,
        OP_PROD_S, OP_PROD_SU, OP_FPROD_U, OP_FPROD_S, OP_FPROD_SU,
        OP_IND_BRANCH
    } mai_op_t;

    typedef enum logic {ST_ISSUE, ST_COMMIT} mai_state_t;
endpackage

/* File: mcu_alu_and_indirect_jump_tb.sv */
// self-checking bench for the execution datapath core
// assumes mai_pkg and mai_alu_core are compiled first; bench drives all ports
`timescale 1ns/1ns
module mcu_alu_and_indirect_jump_tb
    import mai_pkg::*;
;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic opStart = 1'h0;
    mai_op_t opCode = OP_NOP;
    logic [4:0] dstIdx = 5'h00;
    logic [4:0] srcIdx = 5'h00;
    logic [7:0] immK = 8'h00;
    logic [ADDR_W-1:0] busAddr = 6'h00;
    logic [7:0] busWrData = 8'h00;
    logic busWrStb = 1'h0;
    logic busRdStb = 1'h0;
    logic opReady;
    logic [7:0] busRdData;
    logic [7:0] statusOut;
    logic [15:0] pcOut;
    logic [15:0] resultWord;
    // shadow state of the expected machine
    logic [7:0] rf [32];
    logic [7:0] st;
    logic [15:0] pc;
    logic [15:0] word;
    logic pend = 1'h0;
    int errorCnt = 0;
    int testsRun = 0;
    mai_op_t cOp [11] = '{OP_PLUS, OP_PLUS, OP_DIFF_IMM, OP_DIFF_BORROW_IMM,
        OP_DIFF_BORROW, OP_WORD_PLUS, OP_WORD_DIFF, OP_FPROD_S, OP_PROD_SU,
        OP_CLR_BITS, OP_IND_BRANCH};
    logic [4:0] cD [11] = '{2, 4, 7, 6, 3, 31, 6, 5, 5, 2, 0};
    logic [4:0] cS [11] = '{3, 3, 0, 0, 3, 0, 0, 5, 2, 0, 0};
    logic [7:0] cK [11] = '{0, 0, 1, 8'hFF, 0, 1, 8'hFF, 0, 0, 8'hFF, 0};
    logic [7:0] cR [6] = '{8'hFF, 8'h01, 8'h7F, 8'h80, 8'h00, 8'h00};

    mai_alu_core i_mai_alu_core (.mclk, .rst, .opStart, .opCode, .dstIdx,
        .srcIdx, .immK, .opReady, .busAddr, .busWrData, .busWrStb,
        .busRdStb, .busRdData, .statusOut, .pcOut, .resultWord);

    always #4 mclk = ~mclk;

    task endSim;
        $display("counts: %0d checks, %0d mismatches", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // expected effect of one operation on the shadow state
    task automatic model(input mai_op_t op, input logic [4:0] d,
            input logic [4:0] s, input logic [7:0] k);
        logic [7:0] a, b, r;
        logic [8:0] t;
        logic [4:0] h;
        logic [15:0] w, ea, eb;
        logic [16:0] u;
        logic ci, z, sb, by;
        a = rf[d];
        b = rf[s];
        ci = st[FLAG_C];
        z = st[FLAG_Z] | !(op inside {OP_DIFF_BORROW, OP_DIFF_BORROW_IMM});
        sb = op inside {[OP_DIFF:OP_DIFF_BORROW_IMM]};
        by = op inside {[OP_PLUS:OP_ZERO_MINUS]};
        if (op inside {OP_PLUS, OP_DIFF, OP_DIFF_IMM}) ci = 1'h0;
        if (op inside {OP_DIFF_IMM, OP_DIFF_BORROW_IMM, OP_CONJ_IMM,
            OP_DISJ_IMM, OP_SET_BITS, OP_CLR_BITS}) b = k;
        r = 8'h00;
        case (op) inside
            [OP_PLUS:OP_DIFF_BORROW_IMM]: begin
                t = sb ? a - b - ci : a + b + ci;
                h = sb ? a[3:0] - b[3:0] - ci : a[3:0] + b[3:0] + ci;
                r = t[7:0];
                st[FLAG_C] = t[8];
                st[FLAG_H] = h[4];
                st[FLAG_V] = (a[7] ^ r[7]) & (sb ^ ~(a[7] ^ b[7]));
            end
            OP_CONJ, OP_CONJ_IMM: r = a & b;
            OP_DISJ, OP_DISJ_IMM, OP_SET_BITS: r = a | b;
            OP_EXCL: r = a ^ b;
            OP_CLR_BITS: r = a & (8'hFF - b);
            OP_ZERO_MINUS: r = a & a;
            OP_WORD_PLUS, OP_WORD_DIFF: begin
                w = {rf[d + 5'h01], a};
                u = (op == OP_WORD_PLUS) ? w + k : w - k;
                st[FLAG_C] = u[16];
                st[FLAG_V] = (op == OP_WORD_PLUS) ? ~w[15] & u[15]
                    : w[15] & ~u[15];
                st[FLAG_N] = u[15];
                st[FLAG_S] = u[15] ^ st[FLAG_V];
                st[FLAG_Z] = u[15:0] == 16'h0000;
                rf[d] = u[7:0];
                rf[d + 5'h01] = u[15:8];
                word = u[15:0];
            end
            OP_IND_BRANCH: pc = {rf[31], rf[30]};
            OP_NOP: ;
            default: begin
                ea = {{8{a[7] & !(op inside {OP_PROD_U, OP_FPROD_U})}}, a};
                eb = {{8{b[7] & (op inside {OP_PROD_S, OP_FPROD_S})}}, b};
                w = ea * eb;
                st[FLAG_C] = w[15];
                if (op >= OP_FPROD_U) w = w << 1;
                st[FLAG_Z] = w == 16'h0000;
                rf[0] = w[7:0];
                rf[1] = w[15:8];
                word = w;
            end
        endcase
        if (by) begin
            // logic forms clear overflow and leave carry and half-carry
            if (op >= OP_CONJ) st[FLAG_V] = 1'h0;
            st[FLAG_N] = r[7];
            st[FLAG_Z] = (r == 8'h00) & z;
            rf[d] = r;
            word = {8'h00, r};
        end
    endtask

    // start is left high, or random after a two-cycle op; the caller follows with another start or idle
    task automatic runOp(input mai_op_t op, input logic [4:0] d,
            input logic [4:0] s, input logic [7:0] k);
        opStart <= 1'h1;
        opCode <= op;
        dstIdx <= d;
        srcIdx <= s;
        immK <= k;
        @(posedge mclk);
        model(op, d, s, k);
        if (op >= OP_WORD_PLUS) begin
            // a start raised in the busy cycle must be ignored
            opStart <= 1'($urandom);
            opCode <= mai_op_t'(5'($urandom % 23) + 5'h01);
            @(negedge mclk);
            chk(opReady, 1'h0, "busy not shown");
            @(posedge mclk);
        end
        pend = 1'h1;
    endtask

    always @(negedge mclk) begin
        if (pend) begin
            pend = 1'h0;
            chk(statusOut, st, "status");
            chk(resultWord, word, "result");
            chk(pcOut, pc, "program counter");
            chk(opReady, 1'h1, "not ready");
        end
    end

    task idle;
        opStart <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic busWr(input logic [5:0] a, input logic [7:0] v);
        busAddr <= a;
        busWrData <= v;
        busWrStb <= 1'h1;
        @(posedge mclk);
        busWrStb <= 1'h0;
        @(posedge mclk);
        if (a <= ADDR_GPR_LAST) rf[a[4:0]] = v;
        if (a == ADDR_STATUS) st = v;
        if (a == ADDR_PC_LO) pc[7:0] = v;
        if (a == ADDR_PC_HI) pc[15:8] = v;
    endtask

    task automatic busRd(input logic [5:0] a, input logic [7:0] v);
        busAddr <= a;
        busRdStb <= 1'h1;
        @(posedge mclk);
        busRdStb <= 1'h0;
        @(negedge mclk);
        chk(busRdData, v, "read data");
        @(negedge mclk);
        chk(busRdData, 8'h00, "read data not cleared");
        @(posedge mclk);
    endtask

    task chkRegs;
        for (int i = 0; i < 32; i++) busRd(6'(i), rf[i]);
        busRd(ADDR_STATUS, st);
        busRd(ADDR_PC_LO, pc[7:0]);
        busRd(ADDR_PC_HI, pc[15:8]);
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        errorCnt++;
        $display("wrong value at %0t: %s", $time, "run timed out");
        endSim();
    end

    initial begin
        for (int i = 0; i < 32; i++) rf[i] = 8'h00;
        st = STATUS_RESET;
        pc = PC_RESET;
        word = 16'h0000;
        void'($urandom(19610));
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        pend = 1'h1;
        @(posedge mclk);
        chkRegs();
        $display("test reset done");
        for (int i = 0; i < 6; i++) busWr(6'(i + 2), cR[i]);
        busWr(ADDR_STATUS, 8'h00);
        // corners issued back to back: carry, overflow, borrow chain, wrap
        for (int i = 0; i < 11; i++) runOp(cOp[i], cD[i], cS[i], cK[i]);
        idle();
        chkRegs();
        $display("test corners done");
        for (int i = 0; i < 32; i++) busWr(6'(i), 8'($urandom));
        busWr(ADDR_STATUS, 8'($urandom));
        for (int o = 0; o < 24; o++) begin
            runOp(mai_op_t'(5'(o)), 5'($urandom), 5'($urandom), 8'($urandom));
        end
        idle();
        chkRegs();
        $display("test every operation done");
        for (int n = 0; n < 600; n++) begin
            runOp(mai_op_t'(5'($urandom % 23) + 5'h01), 5'($urandom),
                5'($urandom), 8'($urandom));
            if ($urandom % 5 == 0) idle();
            if (n % 150 == 149) begin
                idle();
                chkRegs();
            end
        end
        idle();
        $display("test random operations done");
        busWr(6'h30, 8'hA5);
        busRd(6'h30, 8'h00);
        busRd(6'h3F, 8'h00);
        // program counter bytes are writable from the port as well
        busWr(ADDR_PC_LO, 8'($urandom));
        busWr(ADDR_PC_HI, 8'($urandom));
        chkRegs();
        $display("test unmapped access done");
        endSim();
    end
endmodule
